// ==== verilog/tcq_pkg.sv ====
// constants shared by the transmit and configuration queue access block
package tcq_pkg;
  // ==========================================================
  // register offsets (write address; read address has bit 0 set)
  localparam logic [7:0] TCQ_OFS_LOAD_PORT = 8'h00;
  localparam logic [7:0] TCQ_OFS_ADVANCE   = 8'hb0;
  localparam logic [7:0] TCQ_OFS_LOAD_PTR  = 8'hc0;
  localparam logic [7:0] TCQ_OFS_CFG_PORT  = 8'hd0;
  localparam logic [7:0] TCQ_OFS_CFG_PTR   = 8'hd2;
  localparam logic [7:0] TCQ_OFS_STATE     = 8'hdc;
  localparam int         TCQ_RD_BIT        = 0;
  // ==========================================================
  // field layout
  localparam int TCQ_IDX_W   = 5;
  localparam int TCQ_QSEL_W  = 2;
  localparam int TCQ_STATE_W = 3;
  localparam int TCQ_IDX_LSB = 0;
  localparam int TCQ_QSEL_LSB = 5;
  // ==========================================================
  // limits and reset values
  localparam logic [4:0] TCQ_LOAD_LAST     = 5'h1e;
  localparam logic [4:0] TCQ_CFG_LAST_WIDE = 5'h1d;
  localparam logic [4:0] TCQ_CFG_LAST_Q3   = 5'h05;
  localparam logic [1:0] TCQ_CFG_SHORT_Q   = 2'h3;
  localparam logic [7:0] TCQ_LOAD_RESET    = 8'h00;
  localparam logic [7:0] TCQ_CFG_RESET     = 8'hff;
  localparam logic [7:0] TCQ_ZERO_BYTE     = 8'h00;
endpackage : tcq_pkg

// ==== verilog/tcq_byte_ram.sv ====
// byte memory with one write port, two asynchronous read ports, reset fill
`timescale 1ns/10ps
module tcq_byte_ram #(
  parameter int         AW         = 7,
  parameter logic [7:0] RESET_BYTE = 8'h00
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddrA,
  output logic      [7:0]    rdataA,
  input  wire logic [AW-1:0] raddrB,
  output logic      [7:0]    rdataB
);
  logic [7:0] mem [2**AW];

  // reset fill keeps readback defined before software loads anything
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem[i] <= RESET_BYTE;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdataA = mem[raddrA];
  assign rdataB = mem[raddrB];
endmodule : tcq_byte_ram

// ==== verilog/tcq_access.sv ====
// register bank giving the host byte access to the load queues and config memory
`timescale 1ns/10ps
// Function
// R1: load port accesses the selected load queue, starting at the pointer location 0..30
// R2: burst writes aimed beyond location 30 are dropped, queue unchanged
// R3: each load port byte advances the load pointer; bus address stays fixed
// R4: load pointer is five bits and steps by one per port access
// R5: advance command clears the load pointer to zero (code clears it only for the write address b0; a read advance at b1 leaves it)
// R6: config port accesses byte at queue select and index; port resets to ff
// R7: each config port byte advances the config pointer; bus address stays fixed
// R8: config queue select sits in bits 6:5, read and write
// R9: config queue select wraps from three to zero
// R10: for queues 0..2 writing index 30 or more is ignored
// R11: for queue 3 writing index 6 or more is ignored
// R12: index steps each config access; rollover steps the queue select
// R13: three-bit read-only state readback, resets to zero
// R14: index rolls over after 29 for queues 0..2, after 5 for queue 3
// R15: advance command steps the host load queue then loads that queue
// R16: two-bit host load queue select picks the queue the load port targets
module tcq_access import tcq_pkg::*; #(
  parameter int QSEL_W = TCQ_QSEL_W,
  parameter int IDX_W  = TCQ_IDX_W
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    cmdValid,
  input  wire logic [7:0]              cmdAddr,
  input  wire logic                    byteValid,
  input  wire logic [7:0]              byteWdata,
  input  wire logic [TCQ_STATE_W-1:0]  opState,
  input  wire logic [QSEL_W+IDX_W-1:0] txRdAddr,
  output logic      [7:0]              byteRdata,
  output logic      [QSEL_W-1:0]       loadQueueSel,
  output logic      [7:0]              txRdData
);
  // ==========================================================
  // elaboration check
  if (QSEL_W != TCQ_QSEL_W || IDX_W != TCQ_IDX_W) begin : g_chk
    $error("tcq_access: field widths fixed by the register layout");
  end

  // ==========================================================
  // declarations
  localparam int AW = QSEL_W + IDX_W;
  logic [7:0]        addr_q;
  logic [IDX_W-1:0]  loadPtr_q;
  logic [QSEL_W-1:0] loadQueueSel_q;
  logic [QSEL_W-1:0] cfgQueue_q;
  logic [IDX_W-1:0]  cfgIdx_q;
  logic [TCQ_STATE_W-1:0] state_q;
  logic [7:0]        byteRdata_q;
  logic [7:0]        txRdData_q;
  logic [7:0]        loadRd;
  logic [7:0]        txUartRd;
  logic [7:0]        cfgRd;
  logic              isRead;
  logic              hitLoad;
  logic              hitLoadPtr;
  logic              hitCfg;
  logic              hitCfgPtr;
  logic              hitState;
  logic              loadWe;
  logic              cfgWe;
  logic              wrByte;
  logic              rdByte;
  logic              advCmd;
  logic [7:0]        rdNext;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:1] == ofs[7:1]);
  endfunction : hit

  function automatic logic [IDX_W-1:0] cfgLast(input logic [QSEL_W-1:0] q);
    cfgLast = (q == TCQ_CFG_SHORT_Q) ? TCQ_CFG_LAST_Q3 : TCQ_CFG_LAST_WIDE; // [R14]
  endfunction : cfgLast

  // true while the load pointer still names a reachable location
  function automatic logic loadInRange(input logic [IDX_W-1:0] p);
    loadInRange = (p <= TCQ_LOAD_LAST); // [R2]
  endfunction : loadInRange

  // ==========================================================
  // decode: the address latched at command time holds for the whole burst
  assign isRead     = addr_q[TCQ_RD_BIT];
  assign hitLoad    = hit(addr_q, TCQ_OFS_LOAD_PORT) || hit(addr_q, TCQ_OFS_ADVANCE); // [R15]
  assign hitLoadPtr = hit(addr_q, TCQ_OFS_LOAD_PTR);
  assign hitCfg     = hit(addr_q, TCQ_OFS_CFG_PORT);
  assign hitCfgPtr  = hit(addr_q, TCQ_OFS_CFG_PTR);
  assign hitState   = hit(addr_q, TCQ_OFS_STATE);
  assign wrByte     = byteValid && !isRead;
  assign rdByte     = byteValid && isRead;
  assign advCmd     = cmdValid && hit(cmdAddr, TCQ_OFS_ADVANCE);
  assign loadWe     = wrByte && hitLoad && loadInRange(loadPtr_q); // [R2]
  assign cfgWe      = wrByte && hitCfg;

  // the bus address is never stepped; only the pointers move during a burst
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= TCQ_OFS_LOAD_PORT;
    end else if (cmdValid) begin
      addr_q <= cmdAddr; // [R3] [R7]
    end
  end

  // ==========================================================
  // load queue select and byte pointer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loadQueueSel_q <= '0;
    end else if (advCmd) begin
      loadQueueSel_q <= loadQueueSel_q + 1'b1; // [R15] [R16]
    end
  end

  // pointer saturates past the last location so a long burst keeps dropping
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loadPtr_q <= '0;
    end else if (advCmd && !cmdAddr[TCQ_RD_BIT]) begin
      loadPtr_q <= '0; // [R5]
    end else if (byteValid && hitLoad) begin
      if (loadInRange(loadPtr_q)) begin
        loadPtr_q <= loadPtr_q + 1'b1; // [R3] [R4]
      end
    end else if (wrByte && hitLoadPtr) begin
      loadPtr_q <= byteWdata[TCQ_IDX_LSB +: IDX_W]; // [R4]
    end
  end

  // location 31 of each load queue exists but is never written from the bus
  tcq_byte_ram #(.AW(AW), .RESET_BYTE(TCQ_LOAD_RESET)) u_load_ram (
    .clk    (clk),
    .rstn   (rstn),
    .we     (loadWe), // [R1] [R16]
    .waddr  ({loadQueueSel_q, loadPtr_q}),
    .wdata  (byteWdata),
    .raddrA ({loadQueueSel_q, loadPtr_q}),
    .rdataA (loadRd),
    .raddrB (txRdAddr),
    .rdataB (txUartRd)
  );

  // ==========================================================
  // config pointer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfgQueue_q <= '0;
      cfgIdx_q   <= '0;
    end else if (byteValid && hitCfg) begin
      if (cfgIdx_q >= cfgLast(cfgQueue_q)) begin
        cfgIdx_q   <= '0; // [R12] [R14]
        cfgQueue_q <= cfgQueue_q + 1'b1; // [R9] [R12]
      end else begin
        cfgIdx_q <= cfgIdx_q + 1'b1; // [R7] [R12]
      end
    end else if (wrByte && hitCfgPtr) begin
      cfgQueue_q <= byteWdata[TCQ_QSEL_LSB +: QSEL_W]; // [R8]
      // validity judged against the queue written in the same byte
      if (byteWdata[TCQ_IDX_LSB +: IDX_W] <= cfgLast(byteWdata[TCQ_QSEL_LSB +: QSEL_W])) begin
        cfgIdx_q <= byteWdata[TCQ_IDX_LSB +: IDX_W]; // [R10] [R11]
      end
    end
  end

  tcq_byte_ram #(.AW(AW), .RESET_BYTE(TCQ_CFG_RESET)) u_cfg_ram (
    .clk    (clk),
    .rstn   (rstn),
    .we     (cfgWe), // [R6]
    .waddr  ({cfgQueue_q, cfgIdx_q}),
    .wdata  (byteWdata),
    .raddrA ({cfgQueue_q, cfgIdx_q}),
    .rdataA (cfgRd),
    .raddrB ('0),
    .rdataB ()
  );

  // ==========================================================
  // state readback and read data
  // state is sampled once, so the readback trails the engine by one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= '0;
    end else begin
      state_q <= opState; // [R13]
    end
  end

  // read source picked from the address latched for the burst; unmapped reads give zero
  always_comb begin
    rdNext = TCQ_ZERO_BYTE;
    if (hitLoad) begin
      rdNext = loadInRange(loadPtr_q) ? loadRd : TCQ_ZERO_BYTE; // [R1]
    end else if (hitLoadPtr) begin
      rdNext = {{(8-IDX_W){1'b0}}, loadPtr_q};
    end else if (hitCfg) begin
      rdNext = cfgRd; // [R6]
    end else if (hitCfgPtr) begin
      rdNext = {1'b0, cfgQueue_q, cfgIdx_q}; // [R8]
    end else if (hitState) begin
      rdNext = {{(8-TCQ_STATE_W){1'b0}}, state_q}; // [R13]
    end
  end

  // data captured before the pointer moves, shown the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byteRdata_q <= TCQ_CFG_RESET; // [R6]
    end else if (rdByte) begin
      byteRdata_q <= rdNext;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txRdData_q <= TCQ_LOAD_RESET;
    end else begin
      txRdData_q <= txUartRd;
    end
  end

  assign byteRdata    = byteRdata_q;
  assign loadQueueSel = loadQueueSel_q;
  assign txRdData     = txRdData_q;
endmodule : tcq_access

// ==== sim/tcq_access_asserts.sv ====
// assertion checker for the queue access register bank
`timescale 1ns/10ps
module tcq_access_asserts import tcq_pkg::*; #(
  parameter int QSEL_W = TCQ_QSEL_W,
  parameter int IDX_W  = TCQ_IDX_W
) (
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire logic                    cmdValid,
  input wire logic [7:0]              cmdAddr,
  input wire logic                    byteValid,
  input wire logic [7:0]              byteWdata,
  input wire logic [TCQ_STATE_W-1:0]  opState,
  input wire logic [QSEL_W+IDX_W-1:0] txRdAddr,
  input wire logic [7:0]              byteRdata,
  input wire logic [QSEL_W-1:0]       loadQueueSel,
  input wire logic [7:0]              txRdData
);
  // ==========================================
  // command tracking
  logic [7:0] lastAddr_q;
  wire logic  rdByte = byteValid && lastAddr_q[0];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) lastAddr_q <= 8'h00;
    else if (cmdValid) lastAddr_q <= cmdAddr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // properties
  property p_adv_step;
    cmdValid && cmdAddr[7:1] == 7'h58 |=> loadQueueSel == QSEL_W'($past(loadQueueSel) + 1'b1);
  endproperty
  property p_sel_hold;
    !(cmdValid && cmdAddr[7:1] == 7'h58) |=> $stable(loadQueueSel);
  endproperty
  property p_rd_hold;
    !rdByte |=> $stable(byteRdata);
  endproperty
  property p_state_rd;
    rdByte && lastAddr_q == 8'hdd |=> byteRdata == {5'h00, $past(opState, 2)};
  endproperty
  property p_lptr_rd;
    rdByte && lastAddr_q == 8'hc1 |=> byteRdata[7:5] == 3'h0;
  endproperty
  property p_cptr_rd;
    rdByte && lastAddr_q == 8'hd3 |=>
      !byteRdata[7] && byteRdata[4:0] <= (byteRdata[6:5] == 2'h3 ? 5'h05 : 5'h1d);
  endproperty
  property p_unmapped;
    rdByte && lastAddr_q == 8'h03 |=> byteRdata == 8'h00;
  endproperty
  // a write byte lands in memory one edge before the uart port can see it
  property p_tx_stable;
    $stable(txRdAddr) && !$past(byteValid) |=> $stable(txRdData);
  endproperty
  a_adv_step: assert property (p_adv_step) else $error("queue select did not step");
  a_sel_hold: assert property (p_sel_hold) else $error("queue select moved");
  a_rd_hold: assert property (p_rd_hold) else $error("read byte changed idle");
  a_state_rd: assert property (p_state_rd) else $error("state readback wrong");
  a_lptr_rd: assert property (p_lptr_rd) else $error("load pointer too wide");
  a_cptr_rd: assert property (p_cptr_rd) else $error("config pointer out of range");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_tx_stable: assert property (p_tx_stable) else $error("tx read data moved");
  c_adv: cover property (cmdValid && cmdAddr == 8'hb0);
  c_state: cover property (rdByte && lastAddr_q == 8'hdd);
  c_cfg: cover property (rdByte && lastAddr_q == 8'hd3);
endmodule : tcq_access_asserts

bind tcq_access tcq_access_asserts #(.QSEL_W(QSEL_W), .IDX_W(IDX_W)) u_chk (
  .clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmdAddr(cmdAddr), .byteValid(byteValid),
  .byteWdata(byteWdata), .opState(opState), .txRdAddr(txRdAddr), .byteRdata(byteRdata),
  .loadQueueSel(loadQueueSel), .txRdData(txRdData));

// ==== sim/tcq_host_model.sv ====
// host side model driving command and data bytes of the register bus
`timescale 1ns/10ps
module tcq_host_model (
  input  wire logic       clk,
  output logic            cmdValid,
  output logic [7:0]      cmdAddr,
  output logic            byteValid,
  output logic [7:0]      byteWdata,
  input  wire logic [7:0] byteRdata
);
  // released lines show the inverse so stale values never look valid
  initial begin
    cmdValid  = 1'b0;
    cmdAddr   = 8'h00;
    byteValid = 1'b0;
    byteWdata = 8'h00;
  end
  task automatic cmd(input logic [7:0] a);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdAddr  <= a;
    @(posedge clk);
    cmdValid <= 1'b0;
    cmdAddr  <= ~a;
  endtask : cmd
  task automatic put(input logic [7:0] d);
    @(posedge clk);
    byteValid <= 1'b1;
    byteWdata <= d;
    @(posedge clk);
    byteValid <= 1'b0;
    byteWdata <= ~d;
  endtask : put
  task automatic get(output logic [7:0] d);
    @(posedge clk);
    byteValid <= 1'b1;
    @(posedge clk);
    byteValid <= 1'b0;
    @(negedge clk);
    d = byteRdata;
  endtask : get
endmodule : tcq_host_model

// ==== sim/tb_tcq_access.sv ====
// self-checking bench for the queue access register bank
`timescale 1ns/10ps
module tb_tcq_access;
  logic       clk      = 1'b0;
  logic       rstn     = 1'b0;
  logic [2:0] opState  = 3'h0;
  logic [6:0] txRdAddr = 7'h00;
  logic       cmdValid;
  logic       byteValid;
  logic [7:0] cmdAddr;
  logic [7:0] byteWdata;
  logic [7:0] byteRdata;
  logic [7:0] txRdData;
  logic [7:0] v;
  logic [1:0] loadQueueSel;
  int         errorCnt       = 0;
  int         samplesChecked = 0;
  always #4 clk = ~clk;
  tcq_host_model h (.clk(clk), .cmdValid(cmdValid), .cmdAddr(cmdAddr),
    .byteValid(byteValid), .byteWdata(byteWdata), .byteRdata(byteRdata));
  tcq_access u_dut (.clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmdAddr(cmdAddr),
    .byteValid(byteValid), .byteWdata(byteWdata), .opState(opState), .txRdAddr(txRdAddr),
    .byteRdata(byteRdata), .loadQueueSel(loadQueueSel), .txRdData(txRdData));
  // ==========================================
  // helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samplesChecked++;
    if (g !== e) begin
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
      errorCnt++;
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic [7:0] d);
    h.cmd(a);
    h.put(d);
  endtask : wb
  task automatic rb(input logic [7:0] a, input logic [7:0] e);
    h.cmd(a);
    h.get(v);
    chk(v, e);
  endtask : rb
  task automatic tx(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    txRdAddr <= a;
    @(posedge clk);
    @(negedge clk);
    chk(txRdData, e);
  endtask : tx
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // scenarios
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rb(8'hc1, 8'h00);
    rb(8'hd3, 8'h00);
    rb(8'hd1, 8'hff);
    rb(8'h01, 8'h00);
    rb(8'hdd, 8'h00);
    @(posedge clk);
    opState <= 3'h5;
    wb(8'hdc, 8'hff);
    rb(8'hdd, 8'h05);
    rb(8'h03, 8'h00);
    wb(8'hc0, 8'h1c);
    h.cmd(8'h00);
    for (logic [7:0] d = 8'ha0; d < 8'ha4; d++) h.put(d);
    rb(8'hc1, 8'h1f);
    tx(7'h1c, 8'ha0);
    tx(7'h1e, 8'ha2);
    tx(7'h1f, 8'h00);
    wb(8'hc0, 8'h1e);
    rb(8'h01, 8'ha2);
    h.get(v);
    chk(v, 8'h00);
    wb(8'hb0, 8'h55);
    chk({6'h00, loadQueueSel}, 8'h01);
    rb(8'hc1, 8'h01);
    tx(7'h20, 8'h55);
    rb(8'hb1, 8'h00);
    chk({6'h00, loadQueueSel}, 8'h02);
    wb(8'hd2, 8'h64);
    h.cmd(8'hd0);
    for (logic [7:0] d = 8'h11; d < 8'h44; d += 8'h11) h.put(d);
    rb(8'hd3, 8'h01);
    wb(8'hd2, 8'h66);
    rb(8'hd3, 8'h61);
    wb(8'hd2, 8'h1e);
    rb(8'hd3, 8'h01);
    wb(8'hd2, 8'h1d);
    rb(8'hd1, 8'hff);
    h.get(v);
    chk(v, 8'hff);
    rb(8'hd3, 8'h21);
    wb(8'hd2, 8'h64);
    h.cmd(8'hd1);
    for (logic [7:0] d = 8'h11; d < 8'h44; d += 8'h11) begin
      h.get(v);
      chk(v, d);
    end
    report_and_stop;
  end
  // a hung sequence ends the run as a failure
  initial begin
    repeat (5000) @(posedge clk);
    errorCnt++;
    report_and_stop;
  end
endmodule : tb_tcq_access
